// [shared/vdm_pkg.sv]
/*
 constants, types and register layout of the voltage detect monitor.
 assumes one 25 MHz clock and a plain strobe register port.
*/
// Function
// - software picks the trip level and which side of it counts.
// - a level past the trip level on that side sets the sticky flag, crossing or not.
// - a set flag with the interrupt enabled raises the interrupt request.
// - the flag may come up set out of reset.
// - control bit 15 powers the detector on when one, off when zero.
// - control bits 10 and 9 are reserved and always read one.
// - a flag clear is ignored while live event status is one.
package vdm_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_LEVEL_IN = 4'h3;
    localparam int BIT_POWER = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int BIT_DIRECTION = 11;
    localparam int BIT_RSV_HI = 10;
    localparam int BIT_RSV_LO = 9;
    localparam int BIT_LIVE = 8;
    localparam int LEVEL_W = 4;
    localparam logic [LEVEL_W-1:0] LEVEL_EXTERNAL = 4'hf;
    localparam logic [DATA_W-1:0] CONTROL_WRITE_MASK = 16'ha80f;
    localparam logic [DATA_W-1:0] CONTROL_RESERVED_ONES = 16'h0600;
    localparam int STAT_FLAG = 0;
    localparam int STAT_SETTLED = 1;
    localparam int STAT_W = 2;
    localparam logic [STAT_W-1:0] STAT_RESET = 2'h1;
    localparam int CLK_MHZ = 25;
    localparam int SETTLE_NS = 5000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {VDM_OFF, VDM_SETTLING, VDM_ARMED} vdm_state_t;
endpackage

// [design/vdm_settle_timer.sv]
/*
 settling counter: counts cycles after power enable, pulses once when done.
 assumes a synchronous active-low reset copy.
*/
`timescale 1ns/1ps
`default_nettype none
module vdm_settle_timer #(
    parameter int COUNT = vdm_pkg::SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic done
);
    import vdm_pkg::*;
    localparam int CW = $clog2(COUNT + 1);
    logic [CW-1:0] cnt_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            done <= 1'b0;
        end else if (!run) begin
            cnt_ff <= '0;
            done <= 1'b0;
        end else begin
            done <= (cnt_ff == CW'(COUNT - 1));
            if (cnt_ff != CW'(COUNT))
                cnt_ff <= cnt_ff + 1'b1;
        end
    end
endmodule
`default_nettype wire

// [design/vdm_detect.sv]
/*
 trip comparison: direction chooses at-or-above or below the trip level as the condition.
 assumes the measured code comes from an outside converter, synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module vdm_detect (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic direction,
    input wire logic [vdm_pkg::LEVEL_W-1:0] level_sel,
    input wire logic [vdm_pkg::LEVEL_W-1:0] measured,
    input wire logic ext_above,
    output logic cond
);
    import vdm_pkg::*;
    logic above;
    always_comb begin
        if (level_sel == LEVEL_EXTERNAL)
            above = ext_above;
        else
            above = (measured >= level_sel);
    end
    // condition is a level; gated off when powered down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            cond <= 1'b0;
        else
            cond <= enable & (direction ? above : ~above);
    end
endmodule
`default_nettype wire

// [design/vdm_top.sv]
/*
 voltage detect monitor: control register, sticky flag, live status, irq.
 assumes a digital level code for the supply and a comparator bit for
 the external input; the analog parts sit outside.
*/
`timescale 1ns/1ps
`default_nettype none
module vdm_top #(
    parameter int SETTLE = vdm_pkg::SETTLE_CYC
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic [vdm_pkg::ADDR_W-1:0] ADDR,
    input wire logic [vdm_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [vdm_pkg::DATA_W-1:0] RDATA,
    input wire logic [vdm_pkg::LEVEL_W-1:0] SUPPLY_LEVEL,
    input wire logic EXT_ABOVE,
    output logic DETECT_POWER,
    output logic IRQ
);
    import vdm_pkg::*;

    ////////////////////////////////////////////////////////////////
    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////
    logic power_ff;
    logic idle_stop_ff;
    logic direction_ff;
    logic [LEVEL_W-1:0] level_ff;
    logic [STAT_W-1:0] status_ff;
    logic [STAT_W-1:0] mask_ff;
    logic cond;
    logic settle_done;
    vdm_state_t state_ff;
    logic wr_ctl;
    logic rd_stat;
    logic flag_clear;
    logic [STAT_W-1:0] nxt_status;

    assign wr_ctl = WR && (ADDR == ADDR_CONTROL);
    assign rd_stat = RD && (ADDR == ADDR_STATUS);

    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            power_ff <= 1'b0;
            idle_stop_ff <= 1'b0;
            direction_ff <= 1'b0;
            level_ff <= '0;
        end else if (wr_ctl) begin
            power_ff <= WDATA[BIT_POWER];
            idle_stop_ff <= WDATA[BIT_IDLE_STOP];
            direction_ff <= WDATA[BIT_DIRECTION];
            level_ff <= WDATA[LEVEL_W-1:0];
        end
    end

    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff)
            mask_ff <= '0;
        else if (WR && (ADDR == ADDR_MASK))
            mask_ff <= WDATA[STAT_W-1:0];
    end

    ////////////////////////////////////////////////////////////////
    vdm_detect u_detect (
        .clk(MCLK),
        .rst_n(rst_n_ff),
        .enable(power_ff),
        .direction(direction_ff),
        .level_sel(level_ff),
        .measured(SUPPLY_LEVEL),
        .ext_above(EXT_ABOVE),
        .cond(cond)
    );

    vdm_settle_timer #(.COUNT(SETTLE)) u_settle (
        .clk(MCLK),
        .rst_n(rst_n_ff),
        .run(power_ff),
        .done(settle_done)
    );

    // settling only informs software; detection is never blocked by it
    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff)
            state_ff <= VDM_OFF;
        else begin
            case (state_ff)
                VDM_OFF: if (power_ff) state_ff <= VDM_SETTLING;
                VDM_SETTLING: begin
                    if (!power_ff)
                        state_ff <= VDM_OFF;
                    else if (settle_done)
                        state_ff <= VDM_ARMED;
                end
                VDM_ARMED: if (!power_ff) state_ff <= VDM_OFF;
                default: state_ff <= VDM_OFF;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // clear by reading status; refused while the condition still holds
    assign flag_clear = rd_stat && !cond;
    always_comb begin
        nxt_status = status_ff;
        if (flag_clear)
            nxt_status[STAT_FLAG] = 1'b0;
        if (rd_stat)
            nxt_status[STAT_SETTLED] = 1'b0;
        if (cond)
            nxt_status[STAT_FLAG] = 1'b1;
        if (settle_done && (state_ff == VDM_SETTLING))
            nxt_status[STAT_SETTLED] = 1'b1;
    end

    // flag comes up set out of reset, software must clear it first
    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff)
            status_ff <= STAT_RESET;
        else
            status_ff <= nxt_status;
    end

    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff)
            IRQ <= 1'b0;
        else
            IRQ <= |(nxt_status & mask_ff);
    end

    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff)
            DETECT_POWER <= 1'b0;
        else
            DETECT_POWER <= (wr_ctl ? WDATA[BIT_POWER] : power_ff);
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff)
            RDATA <= '0;
        else if (RD) begin
            if (ADDR == ADDR_CONTROL) begin
                RDATA <= CONTROL_RESERVED_ONES;
                RDATA[BIT_POWER] <= power_ff;
                RDATA[BIT_IDLE_STOP] <= idle_stop_ff;
                RDATA[BIT_DIRECTION] <= direction_ff;
                RDATA[BIT_LIVE] <= cond;
                RDATA[LEVEL_W-1:0] <= level_ff;
            end else if (ADDR == ADDR_STATUS) begin
                RDATA <= DATA_W'(status_ff);
            end else if (ADDR == ADDR_MASK) begin
                RDATA <= DATA_W'(mask_ff);
            end else if (ADDR == ADDR_LEVEL_IN) begin
                RDATA <= DATA_W'({EXT_ABOVE, SUPPLY_LEVEL});
            end else begin
                RDATA <= '0;
            end
        end else
            RDATA <= '0;
    end
endmodule
`default_nettype wire

// [verif/vdm_props.sv]
/* checker: power copy, readback and irq relations at the vdm_top ports.
 assumes a bind to vdm_top and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module vdm_props import vdm_pkg::*; #(
    parameter int SETTLE = 4
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic [vdm_pkg::ADDR_W-1:0] ADDR,
    input wire logic [vdm_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [vdm_pkg::DATA_W-1:0] RDATA,
    input wire logic [vdm_pkg::LEVEL_W-1:0] SUPPLY_LEVEL,
    input wire logic EXT_ABOVE,
    input wire logic DETECT_POWER,
    input wire logic IRQ
);
    logic [1:0] mask_ff;
    // shadow of the mask, so irq can be judged from the ports alone
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) mask_ff <= 2'h0;
        else if (WR && ADDR == ADDR_MASK) mask_ff <= WDATA[1:0];
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    sequence rd_ctl; RD && ADDR == ADDR_CONTROL; endsequence
    sequence rd_off; RD && ADDR == ADDR_STATUS && !DETECT_POWER; endsequence
    power_follow_a: assert property (WR && ADDR == ADDR_CONTROL |=> DETECT_POWER == $past(WDATA[BIT_POWER]))
        else $error("power copy wrong");
    power_hold_a: assert property (!(WR && ADDR == ADDR_CONTROL) |=> $stable(DETECT_POWER))
        else $error("power moved");
    power_read_a: assert property (rd_ctl |=> RDATA[BIT_POWER] == DETECT_POWER)
        else $error("power readback wrong");
    rsv_ones_a: assert property (rd_ctl |=> RDATA[BIT_RSV_HI:BIT_RSV_LO] == 2'b11)
        else $error("reserved bits not one");
    off_live_a: assert property ((!DETECT_POWER)[*4] ##1 rd_ctl |=> !RDATA[BIT_LIVE])
        else $error("live status while off");
    off_flag_a: assert property ((!DETECT_POWER)[*4] ##1 rd_off ##2 rd_off |=> RDATA[1:0] == 2'b00)
        else $error("flag set while off");
    irq_match_a: assert property (RD && ADDR == ADDR_STATUS && !$past(WR) |=> $past(IRQ) == |(RDATA[1:0] & mask_ff))
        else $error("irq differs from status and mask");
    irq_masked_a: assert property (mask_ff == 2'b00 && $past(mask_ff) == 2'b00 |-> !IRQ)
        else $error("irq while masked");
endmodule
`default_nettype wire

// [verif/vdm_supply_model.sv]
/* supply rail model: moves the level code toward a target.
 assumes the bench sets target, external level and pace. */
`timescale 1ns/1ps
`default_nettype none
module vdm_supply (
    input wire logic clk,
    input wire logic slow,
    input wire logic [vdm_pkg::LEVEL_W-1:0] target,
    input wire logic ext_target,
    output logic [vdm_pkg::LEVEL_W-1:0] level,
    output logic ext_above
);
    import vdm_pkg::*;
    initial level = '0;
    initial ext_above = 1'b0;
    // slow mode ramps one code a cycle, so crossings pass every code
    always @(posedge clk) begin
        ext_above <= ext_target;
        if (!slow || level == target) level <= target;
        else level <= (level < target) ? level + 1'b1 : level - 1'b1;
    end
endmodule
`default_nettype wire

// [verif/testbench.sv]
/* testbench: reset values, random trip setups, clear refusal, irq.
 assumes vdm_top with a short settle count and the supply model. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import vdm_pkg::*;
    localparam int SET = 4;
    logic MCLK = 0, RSTN = 0, WR = 0, RD = 0, slow = 0, ext = 0, ext_lvl, DETECT_POWER, IRQ, c;
    logic [ADDR_W-1:0] ADDR = '0;
    logic [DATA_W-1:0] WDATA = '0, RDATA, cfg;
    logic [LEVEL_W-1:0] sup, tgt = '0;
    logic [31:0] seed = 32'd74438;
    int fail_count = 0, num_checks = 0;
    always #20 MCLK = ~MCLK;
    vdm_supply u_sup (.clk(MCLK), .slow(slow), .target(tgt), .ext_target(ext), .level(sup), .ext_above(ext_lvl));
    vdm_top #(.SETTLE(SET)) uut (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .SUPPLY_LEVEL(sup), .EXT_ABOVE(ext_lvl), .DETECT_POWER(DETECT_POWER), .IRQ(IRQ));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic econd(logic [15:0] f, logic [3:0] s, logic e);
        if (f[3:0] == LEVEL_EXTERNAL) return f[BIT_DIRECTION] ? e : !e;
        return f[BIT_DIRECTION] ? (s >= f[3:0]) : (s < f[3:0]);
    endfunction
    function automatic logic [15:0] ectl(logic [15:0] f, logic l);
        return (f & CONTROL_WRITE_MASK) | CONTROL_RESERVED_ONES | (16'(l) << BIT_LIVE);
    endfunction
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge MCLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [15:0] e, logic k = 1'b1);
        @(posedge MCLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD <= 1'b0;
        @(negedge MCLK);
        if (k) `CHK(RDATA, e)
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge MCLK);
        RSTN <= 1'b1;
        repeat (3) @(posedge MCLK);
        rd(ADDR_STATUS, 16'h0001);
        rd(ADDR_STATUS, 16'h0000);
        rd(ADDR_CONTROL, CONTROL_RESERVED_ONES);
        rd(4'h7, 16'h0000);
        for (int i = 0; i < 12; i++) begin
            cfg = 16'(rnd()) & 16'h7fff;
            if (i == 0) cfg[3:0] = LEVEL_EXTERNAL;
            tgt <= (i == 1) ? cfg[3:0] : 4'(rnd());
            {slow, ext} <= 2'(rnd());
            wr(ADDR_CONTROL, cfg);
            repeat (16) @(posedge MCLK);
            c = econd(cfg, tgt, ext);
            rd(ADDR_LEVEL_IN, {11'h0, ext, tgt});
            wr(ADDR_MASK, 16'h0003);
            rd(ADDR_MASK, 16'h0003);
            wr(ADDR_CONTROL, cfg | 16'h8000);
            rd(ADDR_STATUS, 16'h0000);
            `CHK(DETECT_POWER, 1'b1)
            repeat (SET + 8) @(posedge MCLK);
            @(negedge MCLK);
            `CHK(IRQ, 1'b1)
            rd(ADDR_STATUS, {14'h0, 1'b1, c});
            rd(ADDR_STATUS, {15'h0, c});
            rd(ADDR_CONTROL, ectl(cfg | 16'h8000, c));
            `CHK(IRQ, c)
            wr(ADDR_MASK, 16'h0000);
            wr(ADDR_CONTROL, cfg);
            repeat (4) @(posedge MCLK);
            rd(ADDR_STATUS, {15'h0, c});
            `CHK(DETECT_POWER, 1'b0)
            rd(ADDR_STATUS, 16'h0);
            rd(ADDR_CONTROL, ectl(cfg, 1'b0));
            `CHK(IRQ, 1'b0)
        end
        test_done();
    end
endmodule
bind vdm_top vdm_props #(.SETTLE(SETTLE)) u_props (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SUPPLY_LEVEL(SUPPLY_LEVEL), .EXT_ABOVE(EXT_ABOVE), .DETECT_POWER(DETECT_POWER), .IRQ(IRQ));
`default_nettype wire
